// File: src/etqr_egress_cfg.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "etqr_map.svh"

module etqr_egress_cfg
   import etqr_pkg::*;
(
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [15:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire etqr_pkt_info_type [2:0] pkt_info_in,
   output etqr_tag_action_type [2:0] tag_action_out,
   output etqr_tag_cfg_type [2:0] tag_cfg_out,
   input wire logic [3:0] byte_sent_in,
   output logic [3:0] queue_ready_out
);

   // ---------------------------------------------------------------
   // Register storage
   // ---------------------------------------------------------------
   logic [31:0] tag_rules_r;
   logic [31:0] pace_q01_r;
   logic [31:0] pace_q23_r;
   logic [31:0] prdata_nxt;
   logic hit_nxt;
   logic setup_phase;
   logic write_take;
   logic [31:0] strobe_mask;

   // Setup cycle starts an answer; write lands on the access edge with pready high
   assign setup_phase = psel_in && !penable_in && !pready_out;
   assign write_take = psel_in && penable_in && pready_out && pwrite_in && !pslverr_out;
   assign strobe_mask = {{8{pstrb_in[3]}}, {8{pstrb_in[2]}}, {8{pstrb_in[1]}}, {8{pstrb_in[0]}}};

   // Read mux and address decode; reserved bits never stored, so they read zero
   always_comb begin
      hit_nxt = 1'b1;
      case (paddr_in)
         `ETQR_ADDR_TAG_RULES: prdata_nxt = tag_rules_r & `ETQR_TAG_RULES_MASK;
         `ETQR_ADDR_PACE_Q01: prdata_nxt = pace_q01_r & `ETQR_PACE_MASK;
         `ETQR_ADDR_PACE_Q23: prdata_nxt = pace_q23_r & `ETQR_PACE_MASK;
         default: begin
            prdata_nxt = 32'h00000000;
            hit_nxt = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // APB answer: one wait-free access cycle, unmapped gives pslverr
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h00000000;
      end else if (clk_en_in) begin
         pready_out <= setup_phase;
         pslverr_out <= setup_phase && !hit_nxt;
         prdata_out <= (setup_phase && !pwrite_in) ? prdata_nxt : 32'h00000000;
      end
   end

   // Tagging rule register; reserved lanes masked off on write
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         tag_rules_r <= `ETQR_TAG_RULES_RST;
      end else if (clk_en_in && write_take && paddr_in == `ETQR_ADDR_TAG_RULES) begin
         tag_rules_r <= ((tag_rules_r & ~strobe_mask) | (pwdata_in & strobe_mask))
            & `ETQR_TAG_RULES_MASK;
      end
   end

   // Port 0 pace registers
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pace_q01_r <= `ETQR_PACE_RST;
         pace_q23_r <= `ETQR_PACE_RST;
      end else if (clk_en_in && write_take) begin
         if (paddr_in == `ETQR_ADDR_PACE_Q01) begin
            pace_q01_r <= ((pace_q01_r & ~strobe_mask) | (pwdata_in & strobe_mask)) & `ETQR_PACE_MASK;
         end
         if (paddr_in == `ETQR_ADDR_PACE_Q23) begin
            pace_q23_r <= ((pace_q23_r & ~strobe_mask) | (pwdata_in & strobe_mask)) & `ETQR_PACE_MASK;
         end
      end
   end

   // ---------------------------------------------------------------
   // Egress tag decision
   // ---------------------------------------------------------------
   function automatic etqr_tag_action_type decide(input etqr_tag_cfg_type cfg, input etqr_pkt_info_type pkt);
      etqr_tag_action_type act;
      act = '0;
      act.valid = pkt.valid;
      case (cfg.port_kind)
         ETQR_PT_DUMB: act.strip_tag = (pkt.tag_kind == ETQR_TAG_SPECIAL);
         ETQR_PT_ACCESS: act.strip_tag = (pkt.tag_kind != ETQR_TAG_NONE);
         ETQR_PT_HYBRID: begin
            // Untagged and regular packets use the per-port control bits; priority follows untag_bit only, special is always stripped
            case (pkt.tag_kind)
               ETQR_TAG_NONE: act.insert_tag = cfg.insert_tag && !pkt.untag_bit;
               ETQR_TAG_PRIO: begin
                  act.strip_tag = pkt.untag_bit;
                  act.vid_from_ingress = !pkt.untag_bit;
               end
               ETQR_TAG_REGULAR: begin
                  act.strip_tag = pkt.untag_bit;
                  act.vid_from_egress = !pkt.untag_bit && cfg.change_vid && cfg.change_tag;
                  act.pri_from_egress = !pkt.untag_bit && cfg.change_pri && cfg.change_tag;
               end
               default: act.strip_tag = 1'b1;
            endcase
         end
         ETQR_PT_CPU: act.add_source_tag = 1'b1;
         default: act = '0;
      endcase
      return act;
   endfunction

   // One decision stage per port; registered so the datapath sees clean levels
   genvar gp;
   generate
      for (gp = 0; gp < 3; gp++) begin : g_port
         always_ff @(posedge mclk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
               tag_cfg_out[gp] <= '0;
               tag_action_out[gp] <= '0;
            end else if (clk_en_in) begin
               tag_cfg_out[gp] <= tag_rules_r[gp*`ETQR_PORT_FIELD_STRIDE +: `ETQR_PORT_FIELD_WIDTH];
               tag_action_out[gp] <= decide(
                  tag_rules_r[gp*`ETQR_PORT_FIELD_STRIDE +: `ETQR_PORT_FIELD_WIDTH], pkt_info_in[gp]);
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Port 0 queue pacing
   // ---------------------------------------------------------------
   // Elapsed time is kept in 20 ns ticks; two ticks pass per clock, so an
   // odd interval rounds up to the next whole clock
   logic [12:0] pace_val [3:0];
   logic [13:0] elapsed_r [3:0];
   assign pace_val[0] = pace_q01_r[`ETQR_PACE_LO_POS +: `ETQR_PACE_WIDTH];
   assign pace_val[1] = pace_q01_r[`ETQR_PACE_HI_POS +: `ETQR_PACE_WIDTH];
   assign pace_val[2] = pace_q23_r[`ETQR_PACE_LO_POS +: `ETQR_PACE_WIDTH];
   assign pace_val[3] = pace_q23_r[`ETQR_PACE_HI_POS +: `ETQR_PACE_WIDTH];

   genvar gq;
   generate
      for (gq = 0; gq < 4; gq++) begin : g_queue
         logic [14:0] elapsed_sum;
         assign elapsed_sum = {1'b0, elapsed_r[gq]} + 15'(`ETQR_TICKS_PER_CLK);
         always_ff @(posedge mclk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
               elapsed_r[gq] <= 14'h3fff;
               queue_ready_out[gq] <= 1'b1;
            end else if (clk_en_in) begin
               if (byte_sent_in[gq]) begin
                  elapsed_r[gq] <= 14'h0000;
                  queue_ready_out[gq] <= 1'b0;
               end else begin
                  // Saturate so a long idle queue stays ready
                  elapsed_r[gq] <= elapsed_sum[14] ? 14'h3fff : elapsed_sum[13:0];
                  queue_ready_out[gq] <= elapsed_sum >= ({2'b00, pace_val[gq]} + 15'h0001);
               end
            end
         end

         // Right after a byte the queue holds off
         hold_after_byte_a: assert property (@(posedge mclk_in iff clk_en_in) disable iff (sys_rst_in)
            byte_sent_in[gq] |=> !queue_ready_out[gq])
            else $error("queue ready right after a byte");
         // Shortest pace frees the queue on the second enabled clock after the byte
         fast_pace_a: assert property (@(posedge mclk_in iff clk_en_in) disable iff (sys_rst_in)
            byte_sent_in[gq] ##1 (!byte_sent_in[gq] && pace_val[gq] <= 13'h0001) |=> queue_ready_out[gq])
            else $error("short pace did not release queue");
      end
   endgenerate

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk_in iff clk_en_in); endclocking
   default disable iff (sys_rst_in);

   sequence apb_setup_s;
      psel_in && !penable_in && !pready_out;
   endsequence
   sequence apb_access_s;
      psel_in && penable_in && pready_out;
   endsequence

   apb_one_wait_a: assert property (apb_setup_s |=> pready_out ##1 !pready_out)
      else $error("pready not a single cycle after setup");
   type_write_a: assert property (apb_setup_s ##1 (apb_access_s and (pwrite_in && pstrb_in[2] && pstrb_in[1]
      && pstrb_in[0] && paddr_in == `ETQR_ADDR_TAG_RULES)) |=> tag_rules_r[17:16] == $past(pwdata_in[17:16])
      && tag_rules_r[9:8] == $past(pwdata_in[9:8]) && tag_rules_r[1:0] == $past(pwdata_in[1:0]))
      else $error("egress type field not written");
   ctrl_bits_a: assert property ((apb_access_s and (pwrite_in && pstrb_in[1] && pstrb_in[0] && !pslverr_out
      && paddr_in == `ETQR_ADDR_TAG_RULES)) |=> tag_rules_r[13:10] == $past(pwdata_in[13:10])
      && tag_rules_r[5:2] == $past(pwdata_in[5:2]))
      else $error("tag control bits not written");
   pace01_write_a: assert property ((apb_access_s and (pwrite_in && pstrb_in == 4'hf && !pslverr_out
      && paddr_in == `ETQR_ADDR_PACE_Q01)) |=> pace_val[1] == $past(pwdata_in[25:13])
      && pace_val[0] == $past(pwdata_in[12:0]))
      else $error("queue 0/1 pace not written");
   pace23_write_a: assert property ((apb_access_s and (pwrite_in && pstrb_in == 4'hf && !pslverr_out
      && paddr_in == `ETQR_ADDR_PACE_Q23)) |=> pace_val[3] == $past(pwdata_in[25:13])
      && pace_val[2] == $past(pwdata_in[12:0]))
      else $error("queue 2/3 pace not written");
   reserved_zero_a: assert property (pready_out |-> (prdata_out & ~`ETQR_TAG_RULES_MASK & ~`ETQR_PACE_MASK)
      == 32'h00000000 && (tag_rules_r & ~`ETQR_TAG_RULES_MASK) == 32'h00000000)
      else $error("reserved bits not zero");
   dumb_pass_a: assert property (tag_rules_r[1:0] == 2'h0 && pkt_info_in[0].tag_kind == ETQR_TAG_REGULAR
      |=> !tag_action_out[0].strip_tag)
      else $error("dumb port altered regular packet");
   access_strip_a: assert property (tag_rules_r[9:8] == 2'h1 && pkt_info_in[1].tag_kind != ETQR_TAG_NONE
      |=> tag_action_out[1].strip_tag)
      else $error("access port kept a tag");
   cpu_source_a: assert property (tag_rules_r[17:16] == 2'h3 |=> tag_action_out[2].add_source_tag)
      else $error("cpu port added no source tag");
   hybrid_insert_a: assert property (tag_rules_r[1:0] == 2'h2 && pkt_info_in[0].tag_kind == ETQR_TAG_NONE
      |=> tag_action_out[0].insert_tag == ($past(tag_rules_r[5]) && !$past(pkt_info_in[0].untag_bit)))
      else $error("hybrid insert decision wrong");
   change_gate_a: assert property (tag_rules_r[9:8] == 2'h2 && pkt_info_in[1].tag_kind == ETQR_TAG_REGULAR
      && !tag_rules_r[10] |=> !tag_action_out[1].vid_from_egress && !tag_action_out[1].pri_from_egress)
      else $error("change without change-tag");
   prio_ingress_a: assert property (tag_rules_r[17:16] == 2'h2 && pkt_info_in[2].tag_kind == ETQR_TAG_PRIO
      && !pkt_info_in[2].untag_bit |=> tag_action_out[2].vid_from_ingress)
      else $error("priority tag not given ingress id");

endmodule // etqr_egress_cfg

// File: src/etqr_map.svh
`ifndef ETQR_MAP_SVH
`define ETQR_MAP_SVH

// ---------------------------------------------------------------
// Register indices and byte addresses
// ---------------------------------------------------------------
`define ETQR_IDX_TAG_RULES 16'h1c0c
`define ETQR_IDX_PACE_Q01 16'h1c0d
`define ETQR_IDX_PACE_Q23 16'h1c0e
`define ETQR_ADDR_TAG_RULES (`ETQR_IDX_TAG_RULES * 16'h0004)
`define ETQR_ADDR_PACE_Q01 (`ETQR_IDX_PACE_Q01 * 16'h0004)
`define ETQR_ADDR_PACE_Q23 (`ETQR_IDX_PACE_Q23 * 16'h0004)

// ---------------------------------------------------------------
// Field layout and reset values
// ---------------------------------------------------------------
`define ETQR_PORT_FIELD_STRIDE 8
`define ETQR_PORT_FIELD_WIDTH 6
`define ETQR_PACE_LO_POS 0
`define ETQR_PACE_HI_POS 13
`define ETQR_PACE_WIDTH 13
`define ETQR_TAG_RULES_MASK 32'h003f3f3f
`define ETQR_PACE_MASK 32'h03ffffff
`define ETQR_TAG_RULES_RST 32'h00000000
`define ETQR_PACE_RST 32'h00000000

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define ETQR_CLK_PERIOD_NS 40
`define ETQR_PACE_TICK_NS 20
`define ETQR_TICKS_PER_CLK (`ETQR_CLK_PERIOD_NS / `ETQR_PACE_TICK_NS)

`endif

// File: src/etqr_pkg.sv
package etqr_pkg;

   // ---------------------------------------------------------------
   // Egress port type encodings
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ETQR_PT_DUMB = 2'h0,
      ETQR_PT_ACCESS = 2'h1,
      ETQR_PT_HYBRID = 2'h2,
      ETQR_PT_CPU = 2'h3
   } etqr_port_kind_type;

   // Tag found on the packet heading for a port
   typedef enum logic [1:0] {
      ETQR_TAG_NONE = 2'h0,
      ETQR_TAG_PRIO = 2'h1,
      ETQR_TAG_REGULAR = 2'h2,
      ETQR_TAG_SPECIAL = 2'h3
   } etqr_tag_kind_type;

   // Per-port control field, bit order matches the register byte
   typedef struct packed {
      logic insert_tag;
      logic change_vid;
      logic change_pri;
      logic change_tag;
      etqr_port_kind_type port_kind;
   } etqr_tag_cfg_type;

   // Packet facts offered by the egress datapath
   typedef struct packed {
      logic valid;
      etqr_tag_kind_type tag_kind;
      logic untag_bit;
   } etqr_pkt_info_type;

   // Tag action returned to the egress datapath
   typedef struct packed {
      logic valid;
      logic strip_tag;
      logic insert_tag;
      logic vid_from_ingress;
      logic vid_from_egress;
      logic pri_from_egress;
      logic add_source_tag;
   } etqr_tag_action_type;

endpackage

// File: tb/etqr_egress_partner.sv
`timescale 1ns/1ps

module etqr_egress_partner
   import etqr_pkg::*;
(
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic [3:0] send_req_in,
   input wire logic [3:0] queue_ready_in,
   output logic [3:0] byte_sent_out,
   output logic [3:0] done_out,
   output logic [3:0][15:0] gap_out
);
   // ---------------------------------------------------------------
   // Byte sender per queue
   // ---------------------------------------------------------------
   logic [3:0] busy_r;
   logic [3:0][15:0] cnt_r;

   // One byte per queue. The ready level seen just after the send is stale, so the first two edges are skipped.
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         byte_sent_out <= 4'h0;
         done_out <= 4'h0;
         busy_r <= 4'h0;
         cnt_r <= '0;
         gap_out <= '0;
      end else begin
         for (int q = 0; q < 4; q++) begin
            byte_sent_out[q] <= 1'b0;
            cnt_r[q] <= cnt_r[q] + 16'h0001;
            if (send_req_in[q] && !busy_r[q] && !done_out[q] && queue_ready_in[q]) begin
               byte_sent_out[q] <= 1'b1;
               busy_r[q] <= 1'b1;
               cnt_r[q] <= 16'h0000;
            end else if (busy_r[q] && cnt_r[q] >= 16'h0002 && queue_ready_in[q]) begin
               busy_r[q] <= 1'b0;
               done_out[q] <= 1'b1;
               gap_out[q] <= cnt_r[q] - 16'h0001;
            end
         end
      end
   end
endmodule // etqr_egress_partner

// File: tb/testbench.sv
`timescale 1ns/1ps
`include "etqr_map.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
   $display("mismatch at %0t: got %h expected %h", $time, g, e); end end

module testbench
   import etqr_pkg::*;
;
   // ---------------------------------------------------------------
   // Stimulus signals and counters
   // ---------------------------------------------------------------
   logic mclk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0, send_req = 4'h0, byte_sent, queue_ready, done;
   logic [31:0] prdata;
   logic pready, pslverr;
   etqr_pkt_info_type [2:0] pkt_info = '0;
   etqr_tag_action_type [2:0] tag_action;
   etqr_tag_cfg_type [2:0] tag_cfg;
   logic [3:0][15:0] gap;
   int miscompares = 0;
   int checks = 0;
   logic [31:0] rd;
   logic er;

   always #20 mclk_in = ~mclk_in;

   etqr_egress_cfg dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'b1), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .pkt_info_in(pkt_info),
      .tag_action_out(tag_action), .tag_cfg_out(tag_cfg), .byte_sent_in(byte_sent), .queue_ready_out(queue_ready));

   etqr_egress_partner far_end (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .send_req_in(send_req),
      .queue_ready_in(queue_ready), .byte_sent_out(byte_sent), .done_out(done), .gap_out(gap));

   // ---------------------------------------------------------------
   // Bus tasks
   // ---------------------------------------------------------------
   // The setup starts one edge after entry so psel never gets two assignments in one step
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge mclk_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge mclk_in);
      penable <= 1'b1;
      // No cycle count assumed; a slave that never answers is cut by the watchdog
      do begin
         @(posedge mclk_in);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [31:0] d, input logic e);
      apb(1'b0, a, 32'h0, 4'h0);
      `CHK(rd, d)
      `CHK(er, e)
   endtask

   // Same control byte on all three ports, same packet on each, masked compare of the action
   task automatic tag_case(input logic [5:0] c, input logic [1:0] k, input logic u, input logic [6:0] m,
      input logic [6:0] x);
      apb(1'b1, `ETQR_ADDR_TAG_RULES, {10'h0, c, 2'h0, c, 2'h0, c}, 4'hf);
      pkt_info <= {3{1'b1, k, u}};
      @(posedge mclk_in);
      @(posedge mclk_in);
      for (int p = 0; p < 3; p++) `CHK(tag_action[p] & m, x)
   endtask

   task automatic give_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      repeat (12) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      `CHK(queue_ready, 4'hf)
      rd_chk(`ETQR_ADDR_TAG_RULES, 32'h0, 1'b0);
      rd_chk(`ETQR_ADDR_PACE_Q01, 32'h0, 1'b0);
      rd_chk(`ETQR_ADDR_PACE_Q23, 32'h0, 1'b0);
      rd_chk(16'h703c, 32'h0, 1'b1);
      apb(1'b1, `ETQR_ADDR_TAG_RULES, 32'hffffffff, 4'h2);
      rd_chk(`ETQR_ADDR_TAG_RULES, 32'h00003f00, 1'b0);
      apb(1'b1, `ETQR_ADDR_TAG_RULES, 32'hffffffff, 4'hf);
      rd_chk(`ETQR_ADDR_TAG_RULES, 32'h003f3f3f, 1'b0);
      `CHK(tag_cfg, 18'h3ffff)
      apb(1'b1, `ETQR_ADDR_PACE_Q01, 32'hffffffff, 4'hf);
      rd_chk(`ETQR_ADDR_PACE_Q01, 32'h03ffffff, 1'b0);
      tag_case(6'h00, 2'h3, 1'b0, 7'h7f, 7'h60);
      tag_case(6'h00, 2'h2, 1'b0, 7'h7f, 7'h40);
      tag_case(6'h01, 2'h2, 1'b0, 7'h20, 7'h20);
      tag_case(6'h01, 2'h3, 1'b0, 7'h20, 7'h20);
      tag_case(6'h01, 2'h0, 1'b0, 7'h20, 7'h00);
      tag_case(6'h03, 2'h0, 1'b0, 7'h7f, 7'h41);
      tag_case(6'h22, 2'h0, 1'b0, 7'h30, 7'h10);
      tag_case(6'h22, 2'h0, 1'b1, 7'h10, 7'h00);
      tag_case(6'h16, 2'h2, 1'b0, 7'h24, 7'h04);
      tag_case(6'h16, 2'h2, 1'b1, 7'h20, 7'h20);
      tag_case(6'h12, 2'h2, 1'b0, 7'h04, 7'h00);
      tag_case(6'h0e, 2'h2, 1'b0, 7'h02, 7'h02);
      tag_case(6'h02, 2'h1, 1'b0, 7'h0c, 7'h08);
      tag_case(6'h02, 2'h1, 1'b1, 7'h28, 7'h20);
      tag_case(6'h02, 2'h3, 1'b0, 7'h20, 7'h20);
      tag_case(6'h0c, 2'h2, 1'b0, 7'h7f, 7'h40);
      // Pace q0=5, q1=0, q2=max, q3=6: ready gaps of ceil((pace+1)/2) clocks
      apb(1'b1, `ETQR_ADDR_PACE_Q01, 32'h00000005, 4'hf);
      apb(1'b1, `ETQR_ADDR_PACE_Q23, 32'h0000dfff, 4'hf);
      send_req <= 4'hf;
      for (int n = 0; n < 6000 && done !== 4'hf; n++) @(posedge mclk_in);
      `CHK(gap, {16'd4, 16'd4096, 16'd1, 16'd3})
      give_verdict();
   end

   // Whole run is under 8000 cycles; a hang is cut at 20000
   initial begin
      repeat (20000) @(posedge mclk_in);
      miscompares++;
      give_verdict();
   end
endmodule // testbench
